// File: inc/cct_regs.svh
`ifndef CCT_REGS_SVH
`define CCT_REGS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CCT_OFS_CTRL2     8'h55
`define CCT_OFS_CTRL1     8'h56
`define CCT_OFS_STATUS    8'h57
`define CCT_OFS_CAP1_HI   8'h58
`define CCT_OFS_CAP1_LO   8'h59
`define CCT_OFS_CMP1_HI   8'h5a
`define CCT_OFS_CMP1_LO   8'h5b
`define CCT_OFS_CNT_HI    8'h5c
`define CCT_OFS_CNT_LO    8'h5d
`define CCT_OFS_ACNT_HI   8'h5e
`define CCT_OFS_ACNT_LO   8'h5f
`define CCT_OFS_CAP2_HI   8'h60
`define CCT_OFS_CAP2_LO   8'h61
`define CCT_OFS_CMP2_HI   8'h62
`define CCT_OFS_CMP2_LO   8'h63
// ------------------------------------------------------------
// control one fields
// ------------------------------------------------------------
`define CCT_C1_CAP_IE     7
`define CCT_C1_CMP_IE     6
`define CCT_C1_OVF_IE     5
`define CCT_C1_FORCE2     4
`define CCT_C1_FORCE1     3
`define CCT_C1_LEVEL2     2
`define CCT_C1_EDGE1      1
`define CCT_C1_LEVEL1     0
// ------------------------------------------------------------
// control two fields
// ------------------------------------------------------------
`define CCT_C2_PIN1_EN    7
`define CCT_C2_PIN2_EN    6
`define CCT_C2_PULSE      5
`define CCT_C2_PWM        4
`define CCT_C2_CLK_HI     3
`define CCT_C2_CLK_LO     2
`define CCT_C2_EDGE2      1
`define CCT_C2_EXT_EDGE   0
// ------------------------------------------------------------
// status fields and reset values
// ------------------------------------------------------------
`define CCT_SR_CAP1       7
`define CCT_SR_CMP1       6
`define CCT_SR_OVF        5
`define CCT_SR_CAP2       4
`define CCT_SR_CMP2       3
`define CCT_SR_FREEZE     2
`define CCT_RST_CTRL      8'h00
`define CCT_RST_CNT       16'hfffc
`define CCT_RST_CMP       16'h8000
`define CCT_PWM_RELOAD    16'hfffc
`define CCT_CNT_MAX       16'hffff
`define CCT_DIV_2         3'h1
`define CCT_DIV_4         3'h3
`define CCT_DIV_8         3'h7
`endif

// File: inc/cct_pkg.sv
package cct_pkg;
	typedef enum logic [1:0] {
		CCT_CLK_DIV4,
		CCT_CLK_DIV2,
		CCT_CLK_DIV8,
		CCT_CLK_EXT
	} cct_clk_t;
	typedef enum logic [1:0] {
		CCT_PULSE_IDLE,
		CCT_PULSE_RUN
	} cct_pulse_t;
endpackage : cct_pkg

// File: design/cct_timer.sv
// Operation
// (RULE1) capture flags raise the interrupt only while capture_irq_en is one
// (RULE2) compare flags raise the interrupt only while compare_irq_en is one
// (RULE3) overflow flag raises the interrupt only while overflow_irq_en is one
// (RULE4) force_level2 drives out_level2 onto compare pin two when enabled
// (RULE5) force_level1 drives out_level1 onto compare pin one when enabled
// (RULE6) compare two match copies out_level2; pulse and pwm use pin one
// (RULE7) capture edge bits pick falling or rising trigger per input
// (RULE8) compare one match copies out_level1 to compare pin one
// (RULE9) cmp1_pin_en only routes pin one; compare one keeps running
// (RULE10) cmp2_pin_en only routes pin two; compare two keeps running
// (RULE11) single pulse: capture one edge starts a pulse ended by cmp1_value
// (RULE12) pwm: pulse length from cmp1_value, period from cmp2_value
// (RULE13) clk_sel picks cpu clock divided by four, two, eight or external
// (RULE14) external setting without an external pin stops the counter
// (RULE15) ext_clk_edge picks which external clock edge advances counter
// (RULE16) capture1 flag on capture or pwm period end; cleared status then low
// (RULE17) compare1 flag on match; cleared by status read then low access
// (RULE18) overflow flag on wrap; cleared by status read then count_low access
// (RULE19) alt_count_low access never clears the overflow flag
// (RULE20) capture2 flag on capture two; cleared status then low access
// (RULE21) compare2 flag on match; cleared by status read then low access
// (RULE22) timer_freeze halts prescaler and counter and disables outputs
// (RULE23) pwm compare two match reloads the counter with fffc
// (RULE24) with pwm and single pulse both set only pwm operates
// (RULE25) counter increments once per timer tick and wraps to zero
`include "cct_regs.svh"
module cct_timer #(
	parameter bit HAS_EXT_CLK = 1'b1
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       capture1_in_pin_i,
	input  wire logic       capture2_in_pin_i,
	input  wire logic       ext_clk_pin_i,
	output logic            cmp1_out_pin_o,
	output logic            cmp1_out_en_n_o,
	output logic            cmp2_out_pin_o,
	output logic            cmp2_out_en_n_o,
	output logic            irq_o
);
	import cct_pkg::*;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  ctrl1_reg;
	logic [7:0]  ctrl2_reg;
	logic [4:0]  flags_reg;
	logic        freeze_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cap1_reg;
	logic [15:0] cap2_reg;
	logic [15:0] cmp1_reg;
	logic [15:0] cmp2_reg;
	logic [15:0] cmp1_sh_reg;
	logic [15:0] cmp2_sh_reg;
	logic [7:0]  cmp1_hi_reg;
	logic [7:0]  cmp2_hi_reg;
	logic [2:0]  div_reg;
	logic        ext_reg;
	logic        icp1_reg;
	logic        icp2_reg;
	logic        sr_seen_reg;
	logic        pin1_reg;
	logic        pin2_reg;
	cct_pulse_t  pulse_reg;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic pwm_mode;
	logic pulse_mode;
	logic tick;
	logic ext_edge;
	logic cap1_evt;
	logic cap2_evt;
	logic cnt_write;
	logic [15:0] ref1;
	logic [15:0] ref2;
	logic match1;
	logic match2;
	logic wrap;
	logic acc;
	logic pulse_go;
	logic reload;
	cct_clk_t clk_sel;

	assign clk_sel    = cct_clk_t'(ctrl2_reg[`CCT_C2_CLK_HI:`CCT_C2_CLK_LO]);
	assign pwm_mode   = ctrl2_reg[`CCT_C2_PWM];
	assign pulse_mode = ctrl2_reg[`CCT_C2_PULSE] & ~pwm_mode; // RULE24
	assign acc        = wr_i | rd_i;

	// ------------------------------------------------------------
	// prescaler and counter clock
	// ------------------------------------------------------------
	// ext pin is taken as synchronous; edge seen against last sample
	assign ext_edge = ctrl2_reg[`CCT_C2_EXT_EDGE] ?
		(ext_clk_pin_i & ~ext_reg) : (~ext_clk_pin_i & ext_reg); // RULE15

	always_comb begin
		case (clk_sel) // RULE13
			CCT_CLK_DIV4: tick = (div_reg[1:0] == 2'(`CCT_DIV_4)) & ~freeze_reg;
			CCT_CLK_DIV2: tick = div_reg[0] & ~freeze_reg;
			CCT_CLK_DIV8: tick = (div_reg == `CCT_DIV_8) & ~freeze_reg;
			CCT_CLK_EXT:  tick = HAS_EXT_CLK & ext_edge & ~freeze_reg; // RULE14
			default:      tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_reg <= 3'h0;
			ext_reg <= 1'b0;
		end else begin
			ext_reg <= ext_clk_pin_i;
			if (!freeze_reg) begin
				div_reg <= div_reg + 3'h1; // RULE22
			end
		end
	end

	// pwm uses shadow compare values, reloaded only at period end
	assign ref1   = pwm_mode ? cmp1_sh_reg : cmp1_reg;
	assign ref2   = pwm_mode ? cmp2_sh_reg : cmp2_reg;
	assign match1 = tick & (cnt_reg == ref1);
	assign match2 = tick & (cnt_reg == ref2);
	assign reload = (pwm_mode & match2) | pulse_go; // RULE11 RULE23
	assign wrap   = tick & (cnt_reg == `CCT_CNT_MAX) & ~reload;
	assign cnt_write = wr_i & ((addr_i == `CCT_OFS_CNT_LO) |
		(addr_i == `CCT_OFS_ACNT_LO));

	always_ff @(posedge clk_i) begin
		if (reset_i || cnt_write) begin
			cnt_reg <= `CCT_RST_CNT;
		end else if (reload) begin
			cnt_reg <= `CCT_PWM_RELOAD; // RULE23 RULE11
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h0001; // RULE25
		end
	end

	// ------------------------------------------------------------
	// input capture
	// ------------------------------------------------------------
	assign cap1_evt = ~pwm_mode & (ctrl1_reg[`CCT_C1_EDGE1] ?
		(capture1_in_pin_i & ~icp1_reg) :
		(~capture1_in_pin_i & icp1_reg)); // RULE7
	assign cap2_evt = ctrl2_reg[`CCT_C2_EDGE2] ?
		(capture2_in_pin_i & ~icp2_reg) :
		(~capture2_in_pin_i & icp2_reg); // RULE7
	// single pulse restarts the count so its width follows cmp1_value only
	assign pulse_go = pulse_mode & ~freeze_reg & cap1_evt &
		(pulse_reg == CCT_PULSE_IDLE); // RULE11

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			icp1_reg <= 1'b0;
			icp2_reg <= 1'b0;
			cap1_reg <= 16'h0000;
			cap2_reg <= 16'h0000;
		end else begin
			icp1_reg <= capture1_in_pin_i;
			icp2_reg <= capture2_in_pin_i;
			if (cap1_evt) begin
				cap1_reg <= cnt_reg; // RULE16
			end
			if (cap2_evt) begin
				cap2_reg <= cnt_reg; // RULE20
			end
		end
	end

	// ------------------------------------------------------------
	// status flags: set wins over clear
	// ------------------------------------------------------------
	logic [4:0] set_v;
	logic [4:0] clr_v;
	assign set_v[4] = cap1_evt | (pwm_mode & match2); // RULE16
	assign set_v[3] = ~pwm_mode & match1; // RULE17
	assign set_v[2] = wrap; // RULE18
	assign set_v[1] = cap2_evt; // RULE20
	assign set_v[0] = ~pwm_mode & match2; // RULE21
	assign clr_v[4] = sr_seen_reg & acc & (addr_i == `CCT_OFS_CAP1_LO);
	assign clr_v[3] = sr_seen_reg & acc & (addr_i == `CCT_OFS_CMP1_LO);
	assign clr_v[2] = sr_seen_reg & acc & (addr_i == `CCT_OFS_CNT_LO); // RULE19
	assign clr_v[1] = sr_seen_reg & acc & (addr_i == `CCT_OFS_CAP2_LO);
	assign clr_v[0] = sr_seen_reg & acc & (addr_i == `CCT_OFS_CMP2_LO);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			flags_reg <= 5'h00;
		end else begin
			flags_reg <= set_v | (flags_reg & ~clr_v);
		end
	end

	// status read arms clearing; any later access other than a status read disarms it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sr_seen_reg <= 1'b0;
		end else if (rd_i && addr_i == `CCT_OFS_STATUS) begin
			sr_seen_reg <= 1'b1;
		end else if (acc) begin
			sr_seen_reg <= 1'b0;
		end
	end

	assign irq_o = (ctrl1_reg[`CCT_C1_CAP_IE] & (flags_reg[4] | flags_reg[1]))
		| (ctrl1_reg[`CCT_C1_CMP_IE] & (flags_reg[3] | flags_reg[0])) // RULE2
		| (ctrl1_reg[`CCT_C1_OVF_IE] & flags_reg[2]); // RULE1 RULE3

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl1_reg  <= `CCT_RST_CTRL;
			ctrl2_reg  <= `CCT_RST_CTRL;
			freeze_reg <= 1'b0;
		end else if (wr_i) begin
			case (addr_i)
				`CCT_OFS_CTRL1:  ctrl1_reg <= wdata_i;
				`CCT_OFS_CTRL2:  ctrl2_reg <= wdata_i;
				`CCT_OFS_STATUS: freeze_reg <= wdata_i[`CCT_SR_FREEZE]; // RULE22
				default: ;
			endcase
		end
	end

	// high byte is held aside; the low write lands both, so no torn value
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cmp1_reg    <= `CCT_RST_CMP;
			cmp2_reg    <= `CCT_RST_CMP;
			cmp1_hi_reg <= 8'(`CCT_RST_CMP >> 8);
			cmp2_hi_reg <= 8'(`CCT_RST_CMP >> 8);
		end else if (wr_i) begin
			case (addr_i)
				`CCT_OFS_CMP1_HI: cmp1_hi_reg <= wdata_i;
				`CCT_OFS_CMP1_LO: cmp1_reg    <= {cmp1_hi_reg, wdata_i};
				`CCT_OFS_CMP2_HI: cmp2_hi_reg <= wdata_i;
				`CCT_OFS_CMP2_LO: cmp2_reg    <= {cmp2_hi_reg, wdata_i};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cmp1_sh_reg <= `CCT_RST_CMP;
			cmp2_sh_reg <= `CCT_RST_CMP;
		end else if (!pwm_mode || match2) begin
			cmp1_sh_reg <= cmp1_reg;
			cmp2_sh_reg <= cmp2_reg;
		end
	end

	// ------------------------------------------------------------
	// output levels
	// ------------------------------------------------------------
	logic lvl1;
	logic lvl2;
	logic force1;
	logic force2;
	assign lvl1   = ctrl1_reg[`CCT_C1_LEVEL1];
	assign lvl2   = ctrl1_reg[`CCT_C1_LEVEL2];
	assign force1 = wr_i & (addr_i == `CCT_OFS_CTRL1) & wdata_i[`CCT_C1_FORCE1];
	assign force2 = wr_i & (addr_i == `CCT_OFS_CTRL1) & wdata_i[`CCT_C1_FORCE2];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin1_reg  <= 1'b0;
			pulse_reg <= CCT_PULSE_IDLE;
		end else if (force1) begin
			pin1_reg <= wdata_i[`CCT_C1_LEVEL1]; // RULE5
		end else if (pwm_mode) begin
			if (match2) begin
				pin1_reg <= lvl2; // RULE12 RULE6
			end else if (match1) begin
				pin1_reg <= lvl1; // RULE12
			end
		end else if (pulse_mode) begin
			case (pulse_reg)
				CCT_PULSE_IDLE: if (pulse_go) begin
					pin1_reg  <= lvl2; // RULE11 RULE6
					pulse_reg <= CCT_PULSE_RUN;
				end
				CCT_PULSE_RUN: if (match1) begin
					pin1_reg  <= lvl1; // RULE11
					pulse_reg <= CCT_PULSE_IDLE;
				end
				default: pulse_reg <= CCT_PULSE_IDLE;
			endcase
		end else if (match1) begin
			pin1_reg <= lvl1; // RULE8
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin2_reg <= 1'b0;
		end else if (force2) begin
			pin2_reg <= wdata_i[`CCT_C1_LEVEL2]; // RULE4
		end else if (!pwm_mode && !pulse_mode && match2) begin
			pin2_reg <= lvl2; // RULE6
		end
	end

	// pin enables only gate routing; compare logic runs regardless
	assign cmp1_out_pin_o  = pin1_reg & ~freeze_reg; // RULE22
	assign cmp2_out_pin_o  = pin2_reg & ~freeze_reg;
	assign cmp1_out_en_n_o = ~(ctrl2_reg[`CCT_C2_PIN1_EN] & ~freeze_reg); // RULE9
	assign cmp2_out_en_n_o = ~(ctrl2_reg[`CCT_C2_PIN2_EN] & ~freeze_reg); // RULE10

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`CCT_OFS_CTRL1:   rdata_o <= ctrl1_reg;
				`CCT_OFS_CTRL2:   rdata_o <= ctrl2_reg;
				`CCT_OFS_STATUS:  rdata_o <= {flags_reg, freeze_reg, 2'b00};
				`CCT_OFS_CAP1_HI: rdata_o <= cap1_reg[15:8];
				`CCT_OFS_CAP1_LO: rdata_o <= cap1_reg[7:0];
				`CCT_OFS_CAP2_HI: rdata_o <= cap2_reg[15:8];
				`CCT_OFS_CAP2_LO: rdata_o <= cap2_reg[7:0];
				`CCT_OFS_CMP1_HI: rdata_o <= cmp1_reg[15:8];
				`CCT_OFS_CMP1_LO: rdata_o <= cmp1_reg[7:0];
				`CCT_OFS_CMP2_HI: rdata_o <= cmp2_reg[15:8];
				`CCT_OFS_CMP2_LO: rdata_o <= cmp2_reg[7:0];
				`CCT_OFS_CNT_HI,
				`CCT_OFS_ACNT_HI: rdata_o <= cnt_reg[15:8];
				`CCT_OFS_CNT_LO,
				`CCT_OFS_ACNT_LO: rdata_o <= cnt_reg[7:0];
				default:          rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_ovf_irq;
		@(posedge clk_i) disable iff (reset_i)
		(flags_reg[2] && ctrl1_reg[`CCT_C1_OVF_IE]) |-> irq_o;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq) else $error("ovf irq lost"); // RULE3
	property p_irq_off;
		@(posedge clk_i) disable iff (reset_i)
		(ctrl1_reg[7:5] == 3'h0) |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq not masked"); // RULE1
	property p_wrap_flag;
		@(posedge clk_i) disable iff (reset_i)
		(wrap && !cnt_write) |=> flags_reg[2] && cnt_reg == 16'h0000;
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("wrap"); // RULE18
	property p_freeze_hold;
		@(posedge clk_i) disable iff (reset_i)
		(freeze_reg && !cnt_write) |=> $stable(cnt_reg);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("frozen"); // RULE22
	property p_pwm_reload;
		@(posedge clk_i) disable iff (reset_i)
		(pwm_mode && match2 && !cnt_write) |=> cnt_reg == 16'hfffc;
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("reload"); // RULE23
	property p_cap1_latch;
		@(posedge clk_i) disable iff (reset_i)
		cap1_evt |=> cap1_reg == $past(cnt_reg) && flags_reg[4];
	endproperty
	a_cap1_latch: assert property (p_cap1_latch) else $error("cap1"); // RULE16
	property p_div8;
		@(posedge clk_i) disable iff (reset_i)
		(clk_sel == CCT_CLK_DIV8 && tick) |=> !tick [*7];
	endproperty
	a_div8: assert property (p_div8) else $error("div8 rate"); // RULE13
	property p_alt_keep;
		@(posedge clk_i) disable iff (reset_i)
		(acc && addr_i == `CCT_OFS_ACNT_LO && flags_reg[2]) |=> flags_reg[2];
	endproperty
	a_alt_keep: assert property (p_alt_keep) else $error("alt clr"); // RULE19
endmodule : cct_timer

// File: verification/cct_timer_tb.sv
`include "cct_regs.svh"
module cct_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// signals
	// ----
	localparam logic [7:0] A_C1 = `CCT_OFS_CTRL1, A_C2 = `CCT_OFS_CTRL2;
	localparam logic [7:0] A_ST = `CCT_OFS_STATUS, A_NL = `CCT_OFS_CNT_LO;
	localparam logic [7:0] A_NH = `CCT_OFS_CNT_HI, A_AL = `CCT_OFS_ACNT_LO;
	localparam logic [7:0] A_P1H = `CCT_OFS_CAP1_HI, A_P1L = `CCT_OFS_CAP1_LO;
	localparam logic [7:0] A_P2L = `CCT_OFS_CAP2_LO, A_M1H = `CCT_OFS_CMP1_HI;
	localparam logic [7:0] A_M1L = `CCT_OFS_CMP1_LO, A_M2H = `CCT_OFS_CMP2_HI;
	localparam logic [7:0] A_M2L = `CCT_OFS_CMP2_LO;
	logic       clk_i, reset_i, wr_i, rd_i, cap1, cap2, ext;
	logic [7:0] addr_i, wdata_i, rdata_o, rdata2, rv, rv2, a0, b0, d, d2;
	logic       pin1, en1_n, pin2, en2_n, irq;
	int         fails = 0;
	int         total_checks = 0;
	int         cyc = 0;
	int         hi, per;

	cct_timer cct_timer_i (
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.capture1_in_pin_i(cap1), .capture2_in_pin_i(cap2),
		.ext_clk_pin_i(ext), .cmp1_out_pin_o(pin1), .cmp1_out_en_n_o(en1_n),
		.cmp2_out_pin_o(pin2), .cmp2_out_en_n_o(en2_n), .irq_o(irq)
	);
	// same bus, but built without the external clock pin
	cct_timer #(.HAS_EXT_CLK(1'b0)) cct_timer_x_i (
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata2),
		.capture1_in_pin_i(cap1), .capture2_in_pin_i(cap2),
		.ext_clk_pin_i(ext), .cmp1_out_pin_o(), .cmp1_out_en_n_o(),
		.cmp2_out_pin_o(), .cmp2_out_en_n_o(), .irq_o()
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// ----
	// helpers
	// ----
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			stop_test;
		end
	end

	task chk(input string w, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", w, e, s);
		end
	endtask : chk

	task idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : idle

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rv  = rdata_o;
		rv2 = rdata2;
	endtask : rd

	task rdc(input logic [7:0] a, input logic [7:0] e, input string w);
		rd(a);
		chk(w, rv, e);
	endtask : rdc

	task sbit(input int b, input logic e, input string w);
		rd(A_ST);
		chk(w, rv[b], e);
	endtask : sbit

	task poll(input int b);
		for (int i = 0; i < 3000; i++) begin
			rd(A_ST);
			if (rv[b] === 1'b1)
				break;
		end
	endtask : poll

	// reads 64 clocks apart: the difference is free of prescaler phase
	task cdiff;
		rd(A_NL);
		a0 = rv;
		b0 = rv2;
		repeat (62) @(posedge clk_i);
		rd(A_NL);
		d  = rv - a0;
		d2 = rv2 - b0;
	endtask : cdiff

	task pulses(input int n);
		repeat (n) begin
			@(posedge clk_i);
			ext <= 1'b1;
			repeat (3) @(posedge clk_i);
			ext <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		idle(4);
	endtask : pulses

	task meas;
		hi = 0;
		for (int i = 0; i < 300 && pin1 !== 1'b0; i++) idle(1);
		for (int i = 0; i < 300 && pin1 !== 1'b1; i++) idle(1);
		while (hi < 300 && pin1 === 1'b1) begin
			idle(1);
			hi++;
		end
		per = hi;
		while (per < 600 && pin1 === 1'b0) begin
			idle(1);
			per++;
		end
	endtask : meas
	// ----
	// scenarios
	// ----
	task t_reset;
		rdc(A_NH, 8'hff, "cnt_hi");
		rdc(A_C1, 8'h00, "ctrl1");
		rdc(A_C2, 8'h00, "ctrl2");
		rdc(A_ST, 8'h00, "status");
		rdc(A_M1H, 8'h80, "cmp1_hi");
		rdc(8'h40, 8'h00, "unmapped");
		chk("irq", irq, 0);
		chk("en1_n", en1_n, 1);
	endtask : t_reset

	task t_clk;
		for (int k = 0; k < 3; k++) begin
			wr(A_C2, {4'h0, k[1:0], 2'b00});
			cdiff;
			chk("rate", d, k == 0 ? 16'd16 : (k == 1 ? 16'd32 : 16'd8));
		end
		wr(A_C2, 8'h0d);
		cdiff;
		chk("no_ext_pin", d2, 0);
		rd(A_NL);
		a0 = rv;
		pulses(5);
		rd(A_NL);
		chk("ext_rise", 8'(rv - a0), 5);
		wr(A_C2, 8'h0c);
		rd(A_NL);
		a0 = rv;
		pulses(3);
		rd(A_NL);
		chk("ext_fall", 8'(rv - a0), 3);
	endtask : t_clk

	task t_ovf;
		wr(A_C2, 8'h04);
		wr(A_C1, 8'h20);
		rd(A_ST);
		rd(A_NL);
		sbit(5, 0, "ovf_clr");
		wr(A_NL, 8'h00);
		poll(5);
		chk("ovf_set", rv[5], 1);
		chk("irq_ovf", irq, 1);
		wr(A_C1, 8'h00);
		idle(1);
		chk("irq_ovf_off", irq, 0);
		rd(A_ST);
		rd(A_AL);
		sbit(5, 1, "ovf_kept");
		rd(A_NL);
		sbit(5, 0, "ovf_cleared");
	endtask : t_ovf

	task t_cmp;
		wr(A_C2, 8'h84);
		wr(A_C1, 8'h45);
		wr(A_M1H, 8'h00);
		wr(A_M1L, 8'h10);
		wr(A_M2H, 8'h00);
		wr(A_M2L, 8'h20);
		wr(A_NL, 8'h00);
		idle(1);
		chk("en1_n_on", en1_n, 0);
		chk("en2_n_off", en2_n, 1);
		poll(6);
		chk("cmp1_flag", rv[6], 1);
		chk("pin1_match", pin1, 1);
		chk("irq_cmp", irq, 1);
		poll(3);
		chk("cmp2_flag", rv[3], 1);
		rd(A_M1L);
		sbit(6, 0, "cmp1_clr");
		chk("cmp2_kept", rv[3], 1);
		rd(A_M2L);
		sbit(3, 0, "cmp2_clr");
		chk("irq_cmp_off", irq, 0);
		// force bits act on the write itself, so each level is its own write
		wr(A_C2, 8'hc4);
		wr(A_C1, 8'h14);
		idle(2);
		chk("force2_hi", pin2, 1);
		chk("en2_n_on", en2_n, 0);
		wr(A_C1, 8'h10);
		idle(2);
		chk("force2_lo", pin2, 0);
		wr(A_C1, 8'h09);
		idle(2);
		chk("force1_hi", pin1, 1);
		wr(A_C1, 8'h08);
		idle(2);
		chk("force1_lo", pin1, 0);
		wr(A_C1, 8'h04);
		wr(A_NL, 8'h00);
		poll(3);
		chk("pin2_match", pin2, 1);
	endtask : t_cmp

	task t_cap;
		wr(A_C1, 8'h80);
		wr(A_C2, 8'h06);
		@(posedge clk_i);
		cap1 <= 1'b1;
		idle(4);
		sbit(7, 0, "cap1_wrong_edge");
		@(posedge clk_i);
		cap1 <= 1'b0;
		idle(4);
		sbit(7, 1, "cap1_fall");
		chk("irq_cap", irq, 1);
		@(posedge clk_i);
		cap2 <= 1'b1;
		idle(4);
		sbit(4, 1, "cap2_rise");
		wr(A_C1, 8'h02);
		idle(1);
		chk("irq_cap_off", irq, 0);
		rd(A_ST);
		rd(A_P1L);
		sbit(7, 0, "cap1_clr");
		chk("cap2_kept", rv[4], 1);
		rd(A_P2L);
		sbit(4, 0, "cap2_clr");
	endtask : t_cap

	task t_frz;
		wr(A_C2, 8'hc4);
		wr(A_ST, 8'h04);
		sbit(2, 1, "freeze_bit");
		cdiff;
		chk("frozen", d, 0);
		chk("frz_en1_n", en1_n, 1);
		chk("frz_en2_n", en2_n, 1);
		chk("frz_pin2", pin2, 0);
		rd(A_NH);
		a0 = rv;
		rd(A_NL);
		b0 = rv;
		@(posedge clk_i);
		cap1 <= 1'b1;
		idle(4);
		rdc(A_P1H, a0, "cap1_hi");
		rdc(A_P1L, b0, "cap1_lo");
		wr(A_ST, 8'h00);
		cdiff;
		chk("thawed", d, 32);
	endtask : t_frz

	task t_pwm;
		rd(A_ST);
		rd(A_P1L);
		sbit(7, 0, "cap1_pre");
		wr(A_C1, 8'h04);
		wr(A_C2, 8'h94);
		wr(A_NL, 8'h00);
		meas;
		chk("pwm_high", hi, 42);
		chk("pwm_period", per, 74);
		sbit(7, 1, "pwm_cap1_flag");
		wr(A_C2, 8'hb4);
		meas;
		chk("both_high", hi, 42);
		chk("both_period", per, 74);
	endtask : t_pwm

	task t_pulse;
		int i;
		wr(A_C2, 8'ha4);
		wr(A_C1, 8'h0e);
		@(posedge clk_i);
		cap1 <= 1'b0;
		idle(6);
		@(posedge clk_i);
		cap1 <= 1'b1;
		for (i = 0; i < 20 && pin1 !== 1'b1; i++) idle(1);
		chk("pulse_start", pin1, 1);
		for (i = 0; i < 300 && pin1 === 1'b1; i++) idle(1);
		chk("pulse_end", pin1, 0);
		chk("pulse_len", (i + 1) / 2, 21);
		idle(100);
		chk("pulse_once", pin1, 0);
	endtask : t_pulse
	// ----
	// main sequence
	// ----
	initial begin
		reset_i = 1'b1;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		addr_i  = 8'h00;
		wdata_i = 8'h00;
		cap1    = 1'b0;
		cap2    = 1'b0;
		ext     = 1'b0;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset;
		t_clk;
		t_ovf;
		t_cmp;
		t_cap;
		t_frz;
		t_pwm;
		t_pulse;
		stop_test;
	end
endmodule : cct_timer_tb
